/* e3tt_trail_tx.sv */
// transmit trail identifier registers, frame sequencer and output buffer
//
// Behaviour
// - sixteen byte registers feed trail slot, byte per frame
// - register k is read in frame k+1
// - byte read goes into next frame's slot
// - registers are eight-bit read/write, reset zero
// - insertion only in the G.832 framing format
// - registers at consecutive addresses, 15 highest
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
module e3tt_trail_tx (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [e3tt_pkg::ADDR_W-1:0] addr,
    input wire logic [e3tt_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [e3tt_pkg::DATA_W-1:0] rdata,
    // framer side
    input wire logic frame_start,
    input wire logic g832_mode,
    // trail byte stream toward the slot inserter
    output logic out_valid,
    output logic [e3tt_pkg::DATA_W-1:0] out_data,
    input wire logic out_ready,
    // current frame position
    output logic [e3tt_pkg::POS_W-1:0] frame_pos
);

    ////////////////////////////////////////////////////////////////////////
    // register file

    logic [e3tt_pkg::DATA_W-1:0] id_reg [e3tt_pkg::ID_BYTES];
    wire logic id_hit;
    wire logic stat_hit;
    wire logic [e3tt_pkg::POS_W-1:0] id_idx;
    wire logic [7:0] addr_off;
    wire logic [7:0] status_word;
    wire logic [e3tt_pkg::DATA_W-1:0] next_rdata;

    assign addr_off = addr - e3tt_pkg::ID_BASE;
    assign id_hit = (addr >= e3tt_pkg::ID_BASE)
        && (addr <= e3tt_pkg::ID_LAST);
    assign id_idx = addr_off[e3tt_pkg::POS_W-1:0];
    assign stat_hit = (addr == e3tt_pkg::ADDR_STATUS);

    logic buf_v0;
    logic buf_v1;
    logic [e3tt_pkg::DATA_W-1:0] buf_d0;
    logic [e3tt_pkg::DATA_W-1:0] buf_d1;

    assign status_word = {1'b0, g832_mode, buf_v1, buf_v0, frame_pos};
    // unmapped addresses read as zero
    assign next_rdata = !rd ? e3tt_pkg::RDATA_RESET
        : id_hit ? id_reg[id_idx]
        : stat_hit ? status_word
        : e3tt_pkg::RDATA_RESET;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < e3tt_pkg::ID_BYTES; i++) begin
                id_reg[i] <= e3tt_pkg::ID_RESET;
            end
        end else if (wr && id_hit) begin
            id_reg[id_idx] <= wdata;
        end
    end

    // the check byte in register 0 is taken as written, never computed
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata <= e3tt_pkg::RDATA_RESET;
        end else begin
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // frame sequencer

    wire logic buf_in_ready;
    wire logic push;
    wire logic pop;
    wire logic [e3tt_pkg::DATA_W-1:0] sel_byte;
    wire logic [e3tt_pkg::POS_W-1:0] next_pos;

    // a byte that finds the buffer full is retried next frame, so the
    // position holds rather than skipping an identifier byte
    assign buf_in_ready = !buf_v1;
    assign push = frame_start && g832_mode && buf_in_ready;
    assign pop = buf_v0 && out_ready;
    assign sel_byte = id_reg[frame_pos];
    assign next_pos = (frame_pos == e3tt_pkg::POS_LAST)
        ? e3tt_pkg::POS_RESET
        : frame_pos + 4'h1;

    always_ff @(posedge ref_clk) begin
        if (rst || !g832_mode) begin
            frame_pos <= e3tt_pkg::POS_RESET;
        end else if (push) begin
            frame_pos <= next_pos;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // two-entry output buffer; head entry drives the outputs directly

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            buf_v0 <= 1'b0;
            buf_v1 <= 1'b0;
            buf_d0 <= e3tt_pkg::ID_RESET;
            buf_d1 <= e3tt_pkg::ID_RESET;
        end else if (pop) begin
            if (buf_v1) begin
                buf_d0 <= buf_d1;
                buf_v1 <= 1'b0;
            end else begin
                buf_v0 <= push;
                buf_d0 <= sel_byte;
            end
        end else if (push) begin
            if (!buf_v0) begin
                buf_v0 <= 1'b1;
                buf_d0 <= sel_byte;
            end else begin
                buf_v1 <= 1'b1;
                buf_d1 <= sel_byte;
            end
        end
    end

    assign out_valid = buf_v0;
    assign out_data = buf_d0;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    logic [e3tt_pkg::POS_W-1:0] pos_prev;
    always_ff @(posedge ref_clk) begin
        pos_prev <= frame_pos;
    end

    push_empty_a: assert property (
        push && !buf_v0 |=> out_valid && out_data == $past(sel_byte)
    ) else $error("byte not presented after capture");

    push_select_a: assert property (
        push |-> sel_byte == id_reg[frame_pos]
    ) else $error("wrong identifier register selected");

    pos_advance_a: assert property (
        push && frame_pos != e3tt_pkg::POS_LAST
        |=> frame_pos == pos_prev + 4'h1
    ) else $error("frame position did not advance");

    pos_wrap_a: assert property (
        push && frame_pos == e3tt_pkg::POS_LAST |=> frame_pos == 4'h0
    ) else $error("frame position did not wrap");

    pos_hold_a: assert property (
        g832_mode && !push ##1 g832_mode |-> $stable(frame_pos)
    ) else $error("frame position moved without a frame");

    mode_gate_a: assert property (
        !g832_mode |-> !push ##1 frame_pos == 4'h0
    ) else $error("insertion outside G.832 mode");

    reg_write_a: assert property (
        wr && id_hit |=> id_reg[$past(id_idx)] == $past(wdata)
    ) else $error("identifier write lost");

    reg_read_a: assert property (
        rd && id_hit && !wr |=> rdata == id_reg[$past(id_idx)]
    ) else $error("identifier readback wrong");

    unmapped_a: assert property (
        rd && !id_hit && !stat_hit |=> rdata == 8'h00
    ) else $error("unmapped read not zero");

    stall_hold_a: assert property (
        out_valid && !out_ready |=> out_valid && $stable(out_data)
    ) else $error("stalled byte changed");

    no_overflow_a: assert property (
        buf_v1 |-> !push
    ) else $error("push into full buffer");

    full_cycle_c: cover property (
        push && frame_pos == e3tt_pkg::POS_LAST ##[1:40] push
    );
    buffer_full_c: cover property (buf_v1 && !out_ready);
    mode_drop_c: cover property (buf_v0 ##1 !g832_mode);
    back_to_back_c: cover property (push && pop);

endmodule : e3tt_trail_tx

/* e3tt_pkg.sv */
// constants for the transmit trail identifier byte block
package e3tt_pkg;
    localparam int unsigned ID_BYTES = 16;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned POS_W = 4;
    // byte address of identifier register 0; register 15 sits at 0x47
    localparam logic [7:0] ID_BASE = 8'h38;
    localparam logic [7:0] ID_LAST = 8'h47;
    localparam logic [7:0] ADDR_BYTE_SIX = 8'h3E;
    localparam logic [7:0] ADDR_BYTE_SEVEN = 8'h3F;
    localparam logic [7:0] ADDR_BYTE_EIGHT = 8'h40;
    localparam logic [7:0] ADDR_BYTE_NINE = 8'h41;
    localparam logic [7:0] ADDR_BYTE_TEN = 8'h42;
    localparam logic [7:0] ADDR_BYTE_ELEVEN = 8'h43;
    localparam logic [7:0] ADDR_BYTE_TWELVE = 8'h44;
    // block status register
    localparam logic [7:0] ADDR_STATUS = 8'h50;
    localparam int unsigned STAT_POS_LSB = 0;
    localparam int unsigned STAT_VALID0 = 4;
    localparam int unsigned STAT_VALID1 = 5;
    localparam int unsigned STAT_MODE = 6;
    localparam logic [7:0] ID_RESET = 8'h00;
    localparam logic [3:0] POS_RESET = 4'h0;
    localparam logic [3:0] POS_LAST = 4'hF;
    localparam logic [7:0] RDATA_RESET = 8'h00;
endpackage : e3tt_pkg

/* e3tt_slot_sink.sv */
// slot inserter model that takes trail bytes and stalls on request
`timescale 1ns/100ps
module e3tt_slot_sink (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // stall request from the bench
    input wire logic stall,
    // trail byte handshake
    input wire logic out_valid,
    output logic out_ready
);
    ////////////////////////////////////////////////////////////////////////
    // ready is registered, so a stall bites one edge late, as a real one
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            out_ready <= 1'b0;
        end else begin
            out_ready <= !stall;
        end
    end
endmodule : e3tt_slot_sink

/* e3tt_trail_tx_bench.sv */
// self-checking bench for the trail identifier byte block
`timescale 1ns/100ps
module e3tt_trail_tx_bench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic frame_start = 1'b0;
    logic g832_mode = 1'b0;
    logic stall = 1'b1;
    logic out_ready;
    logic out_valid;
    logic [7:0] rdata;
    logic [7:0] out_data;
    logic [3:0] frame_pos;
    int n_errors = 0;
    int total_checks = 0;
    int n_seen = 0;

    always #12.5 ref_clk = ~ref_clk;

    e3tt_trail_tx u_dut (.ref_clk(ref_clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .frame_start(frame_start), .g832_mode(g832_mode),
        .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
        .frame_pos(frame_pos));
    e3tt_slot_sink u_sink (.ref_clk(ref_clk), .rst(rst), .stall(stall),
        .out_valid(out_valid), .out_ready(out_ready));

    ////////////////////////////////////////////////////////////////////////
    task check(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task end_of_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    task reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : reg_write

    // read data stand only in the cycle after the strobe
    task reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 check("rdata", exp, rdata);
    endtask : reg_read

    task frame;
        @(posedge ref_clk);
        frame_start <= 1'b1;
        @(posedge ref_clk);
        frame_start <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask : frame

    ////////////////////////////////////////////////////////////////////////
    // held positions are retried, so bytes never skip an index;
    // sampled mid-cycle, where the handshake has settled
    always @(negedge ref_clk) begin
        if (!rst && out_valid === 1'b1 && out_ready === 1'b1) begin
            check("out_data", 8'hA0 + 8'(n_seen % 16), out_data);
            n_seen++;
        end
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        n_errors++;
        end_of_test();
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        for (int k = 0; k < 16; k++) begin
            reg_read(8'h38 + 8'(k), 8'h00);
        end
        reg_read(8'h60, 8'h00);
        for (int k = 0; k < 16; k++) begin
            reg_write(8'h38 + 8'(k), 8'hA0 + 8'(k));
        end
        for (int k = 0; k < 16; k++) begin
            reg_read(8'h38 + 8'(k), 8'hA0 + 8'(k));
        end
        g832_mode <= 1'b1;
        stall <= 1'b0;
        repeat (17) frame();
        check("byte count", 8'h11, 8'(n_seen));
        stall <= 1'b1;
        repeat (3) frame();
        check("frame_pos", 8'h03, {4'h0, frame_pos});
        reg_read(8'h50, 8'h73);
        stall <= 1'b0;
        repeat (5) @(posedge ref_clk);
        check("byte count", 8'h13, 8'(n_seen));
        g832_mode <= 1'b0;
        frame();
        check("frame_pos", 8'h00, {4'h0, frame_pos});
        check("byte count", 8'h13, 8'(n_seen));
        end_of_test();
    end
endmodule : e3tt_trail_tx_bench
